// ### psc_pad_model.sv
// pad and reset-source model on the far side of the pin-state block
`timescale 1ns/100ps
module psc_pad_model
  import psc_pkg::*;
#(
  parameter int HOLD_CYC = 20,
  parameter int NP       = 53
)(
  input  wire logic          mclk_i,
  input  wire logic          pull_rst_i,  // bench asks for a reset pulse
  input  wire logic [NP-1:0] ext_i,       // level of the outside sources
  input  wire logic [NP-1:0] pad_out_i,
  input  wire logic [NP-1:0] pad_oe_i,
  output logic [NP-1:0]      pad_in_o,
  output logic               init_n_o
);
  int hold_cnt = 0;

  // ----------------------------------------------------------------
  // reset source
  // ----------------------------------------------------------------
  // hold span is scaled down, the real one would make the run too long
  always @(posedge mclk_i) begin
    if (hold_cnt < HOLD_CYC) hold_cnt <= hold_cnt + 1;
  end
  assign init_n_o = (hold_cnt >= HOLD_CYC) && !pull_rst_i;

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // a driven pad shows its driver, a released one the outside source
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule // psc_pad_model

// ### psc_pin_cell.sv
// one pad cell: output driver gate, input gate and hold latch
`timescale 1ns/100ps
module psc_pin_cell
  import psc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic hold_i,      // keep prior output state
  input  wire logic hiz_i,       // force driver off
  input  wire logic in_en_i,     // input gate open
  input  wire logic func_out_i,  // function output value
  input  wire logic func_oe_i,   // function output enable
  input  wire logic pad_in_i,    // synchronised pad level
  output logic      pad_out_o,
  output logic      pad_oe_o,
  output logic      core_in_o
);

  logic held_out;
  logic held_oe;

  // latch the live drive while not holding so hold shows the prior state
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_out <= 1'b0;
      held_oe  <= PSC_RST_OE;
    end else if (!hold_i) begin
      held_out <= func_out_i;
      held_oe  <= func_oe_i;
    end
  end

  // hold shows the drive latched on the last free cycle; a peripheral that
  // keeps running while held is not followed, its last value stands instead
  wire logic live_out = hold_i ? held_out : func_out_i;
  wire logic live_oe  = hold_i ? held_oe  : func_oe_i;

  assign pad_out_o = live_out;
  assign pad_oe_o  = hiz_i ? 1'b0 : live_oe;
  assign core_in_o = in_en_i ? pad_in_i : 1'b0;  // gate shut gives 0

endmodule // psc_pin_cell

// ### psc_pin_state_control.sv
// pin-state control: power state to pad driver and input gate settings
`timescale 1ns/100ps
module psc_pin_state_control
  import psc_pkg::*;
#(
  parameter int N_IRQ = PSC_N_IRQ,
  parameter int N_ANA = PSC_N_ANA,
  parameter int N_TRG = PSC_N_TRG,
  parameter int N_GEN = PSC_N_GEN
)(
  input  wire logic                           mclk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           external_init_input_n_i,
  input  wire logic                           lvd_reset_i,
  input  wire logic                           first_run_i,
  input  wire logic                           sleep_req_i,
  input  wire logic                           stop_req_i,
  input  wire logic                           stop_float_select_i,
  input  wire logic [N_IRQ-1:0]               irq_sel_i,
  input  wire logic [N_IRQ-1:0]               irq_en_i,
  input  wire logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0] func_out_i,
  input  wire logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0] func_oe_i,
  input  wire logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0] pad_in_i,
  input  wire logic                           nonmaskable_irq_input_n_i,
  output logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0]  pad_out_o,
  output logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0]  pad_oe_o,
  output logic [N_IRQ+N_ANA+N_TRG+N_GEN-1:0]  core_in_o,
  output logic                                nmi_n_o,
  output psc_state_e                          state_o
);

  localparam int NP = N_IRQ + N_ANA + N_TRG + N_GEN;
  // pin order: irq pins low, then analog, then trigger, then general
  localparam int ANA_LO = N_IRQ;
  localparam int ANA_HI = N_IRQ + N_ANA - 1;

  // ----------------------------------------------------------------
  // synchronisers for pad-side inputs
  // ----------------------------------------------------------------
  logic [NP-1:0] pad_s1;
  logic [NP-1:0] pad_s2;
  logic          init_s1;
  logic          init_s2;
  logic          nmi_s1;
  logic          nmi_s2;

  // two flops on every pin level before any gate reads it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_s1  <= '0;
      pad_s2  <= '0;
      init_s1 <= 1'b0;
      init_s2 <= 1'b0;
      nmi_s1  <= 1'b1;
      nmi_s2  <= 1'b1;
    end else begin
      pad_s1  <= pad_in_i;
      pad_s2  <= pad_s1;
      init_s1 <= external_init_input_n_i;
      init_s2 <= init_s1;
      nmi_s1  <= nonmaskable_irq_input_n_i;
      nmi_s2  <= nmi_s1;
    end
  end

  // ----------------------------------------------------------------
  // power state tracking
  // ----------------------------------------------------------------
  psc_state_e state;
  psc_state_e next_state;
  wire logic  in_reset = !init_s2 || lvd_reset_i;

  // reset dominates; sleep and stop follow the request level directly
  always_comb begin
    next_state = state;
    case (state)
      PSC_ST_RESET:    next_state = in_reset ? PSC_ST_RESET : PSC_ST_POSTRST;
      PSC_ST_POSTRST:  next_state = first_run_i ? PSC_ST_RUN : PSC_ST_POSTRST;
      PSC_ST_RUN,
      PSC_ST_SLEEP,
      PSC_ST_STOP_HOLD,
      PSC_ST_STOP_FLOAT: begin
        if (stop_req_i)       next_state = stop_float_select_i ? PSC_ST_STOP_FLOAT
                                                               : PSC_ST_STOP_HOLD;
        else if (sleep_req_i) next_state = PSC_ST_SLEEP;
        else                  next_state = PSC_ST_RUN;
      end
      default:         next_state = PSC_ST_RESET;
    endcase
    if (in_reset) begin
      next_state = PSC_ST_RESET;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= PSC_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // mode decode; uses the live request so state applies from entry
  // ----------------------------------------------------------------
  // decoding from next_state removes a cycle of lag at entry and exit
  wire logic m_reset = (next_state == PSC_ST_RESET);
  wire logic m_post  = (next_state == PSC_ST_POSTRST);
  wire logic m_sleep = (next_state == PSC_ST_SLEEP);
  wire logic m_hold  = (next_state == PSC_ST_STOP_HOLD);
  wire logic m_float = (next_state == PSC_ST_STOP_FLOAT);

  // ----------------------------------------------------------------
  // per-pin control and pad cells
  // ----------------------------------------------------------------
  logic [NP-1:0] pin_hold;
  logic [NP-1:0] pin_hiz;
  logic [NP-1:0] pin_in_en;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      if (g < N_IRQ) begin : g_irq
        // interrupt pins stay usable in sleep and held stop
        wire logic irq_ok = irq_sel_i[g] && irq_en_i[g];
        assign pin_hold[g]  = 1'b0;
        assign pin_hiz[g]   = m_reset || m_post || m_float;
        assign pin_in_en[g] = m_float ? irq_ok : !m_reset;
      end else if (g >= ANA_LO && g <= ANA_HI) begin : g_ana
        assign pin_hold[g]  = m_sleep || m_hold;
        assign pin_hiz[g]   = m_reset || m_post || m_float;
        assign pin_in_en[g] = !(m_reset || m_post || m_float);
      end else begin : g_gen
        assign pin_hold[g]  = m_sleep || m_hold;
        assign pin_hiz[g]   = m_reset || m_post || m_float;
        assign pin_in_en[g] = !(m_reset || m_float);
      end

      psc_pin_cell u_cell (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .hold_i     (pin_hold[g]),
        .hiz_i      (pin_hiz[g]),
        .in_en_i    (pin_in_en[g]),
        .func_out_i (func_out_i[g]),
        .func_oe_i  (func_oe_i[g]),
        .pad_in_i   (pad_s2[g]),
        .pad_out_o  (pad_out_o[g]),
        .pad_oe_o   (pad_oe_o[g]),
        .core_in_o  (core_in_o[g])
      );
    end
  endgenerate

  // nmi input is never gated, in reset or any low-power mode
  assign nmi_n_o = nmi_s2;
  assign state_o = state;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_stop_float;
    (next_state == PSC_ST_STOP_FLOAT);
  endsequence

  // entry into a holding mode: one free cycle, then two held cycles
  sequence s_sleep_entry;
    !(m_sleep || m_hold) ##1 m_sleep [*2];
  endsequence

  sequence s_stop_hold_entry;
    !(m_sleep || m_hold) ##1 m_hold [*2];
  endsequence

  rst_all_hiz_a: assert property (m_reset |-> (pad_oe_o == '0) && (core_in_o == '0))
    else $error("pin driven or input open during reset");
  post_ana_zero_a: assert property (m_post |-> core_in_o[ANA_HI:ANA_LO] == '0)
    else $error("analog input not fixed low after reset");
  post_gen_open_a: assert property (m_post |-> core_in_o[NP-1] == pad_s2[NP-1])
    else $error("general input not enabled after reset");
  post_irq_open_a: assert property (m_post |-> core_in_o[N_IRQ-1:0] == pad_s2[N_IRQ-1:0])
    else $error("interrupt input not enabled after reset");
  post_hiz_a: assert property (m_post |-> pad_oe_o == '0)
    else $error("pin driven after reset release");
  float_hiz_a: assert property (s_stop_float |-> pad_oe_o == '0)
    else $error("pin driven in floating stop");
  float_irq_gate_a: assert property (s_stop_float |->
      core_in_o[N_IRQ-1:0] == (pad_s2[N_IRQ-1:0] & irq_sel_i & irq_en_i))
    else $error("interrupt input gate wrong in floating stop");
  float_gen_zero_a: assert property (s_stop_float |-> core_in_o[NP-1:N_IRQ] == '0)
    else $error("general input not fixed low in floating stop");
  sleep_hold_a: assert property (s_sleep_entry |->
      pad_out_o[NP-1:N_IRQ] == $past(func_out_i[NP-1:N_IRQ], 2))
    else $error("general pin did not hold in sleep");
  stop_hold_a: assert property (s_stop_hold_entry |->
      {pad_out_o[NP-1:N_IRQ], pad_oe_o[NP-1:N_IRQ]} ==
      $past({func_out_i[NP-1:N_IRQ], func_oe_i[NP-1:N_IRQ]}, 2))
    else $error("general pin did not hold in stop");
  sleep_irq_open_a: assert property (m_sleep |-> core_in_o[N_IRQ-1:0] == pad_s2[N_IRQ-1:0])
    else $error("interrupt input closed in sleep");
  stop_irq_open_a: assert property (m_hold |-> core_in_o[0] == pad_s2[0])
    else $error("interrupt input closed in held stop");
  exit_run_a: assert property ((next_state == PSC_ST_RUN) |->
      pad_oe_o == func_oe_i)
    else $error("normal pin function not restored at mode exit");
  exit_out_a: assert property ((next_state == PSC_ST_RUN) |-> pad_out_o == func_out_i)
    else $error("normal drive value not restored at mode exit");
  // the first two edges after reset still show the flops' reset value
  nmi_pass_a: assert property ($past(reset_n_i, 2) |->
      nmi_n_o == $past(nonmaskable_irq_input_n_i, 2))
    else $error("nmi input gated");

endmodule // psc_pin_state_control

// ### psc_pkg.sv
// package of constants and types for the pin-state control block
package psc_pkg;

  // ----------------------------------------------------------------
  // pin groups and counts
  // ----------------------------------------------------------------
  localparam int PSC_N_IRQ  = 7;   // external interrupt pins
  localparam int PSC_N_ANA  = 12;  // analog channel pins
  localparam int PSC_N_TRG  = 2;   // converter trigger pins
  localparam int PSC_N_GEN  = 32;  // other general pins

  // ----------------------------------------------------------------
  // power states seen by the pin logic
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSC_ST_RESET,      // reset pin low or low-voltage reset active
    PSC_ST_POSTRST,    // just after reset release, before first run
    PSC_ST_RUN,
    PSC_ST_SLEEP,
    PSC_ST_STOP_HOLD,  // stop with float select cleared
    PSC_ST_STOP_FLOAT  // stop with float select set
  } psc_state_e;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic       PSC_RST_OE      = 1'b0;
  localparam logic       PSC_RST_IN_EN   = 1'b0;
  localparam int         PSC_CLK_MHZ     = 100;
  localparam int         PSC_PON_HOLD_US = 600;  // power-on reset hold by the reset source
  localparam int         PSC_PON_HOLD_CYC = PSC_PON_HOLD_US * PSC_CLK_MHZ;

endpackage

// ### testbench.sv
// self-checking bench for the pin-state control block
`timescale 1ns/100ps
module testbench;
  import psc_pkg::*;
  localparam int NP = PSC_N_IRQ + PSC_N_ANA + PSC_N_TRG + PSC_N_GEN;
  localparam logic [NP-1:0] IRQ_M = 53'h7f;
  localparam logic [NP-1:0] ANA_M = 53'h7ff80;
  localparam logic [NP-1:0] ONES  = {NP{1'b1}};
  localparam logic [NP-1:0] VAL_A = 53'h12345678abcde;
  localparam logic [NP-1:0] VAL_B = 53'h0edcba9876521;
  localparam logic [NP-1:0] EXT_V = 53'h0a5a5a5a5a5a5;
  logic          mclk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic          lvd = 1'b0, first_run = 1'b0, sleep = 1'b0, stop = 1'b0;
  logic          fsel = 1'b0, pull_rst = 1'b0, nmi_in_n = 1'b1;
  logic [6:0]    irq_sel = 7'h00, irq_en = 7'h00;
  logic [NP-1:0] func_out = '0, func_oe = '0, ext = EXT_V;
  logic [NP-1:0] pad_in, pad_out, pad_oe, core_in;
  logic          init_n, nmi_n;
  psc_state_e    state;
  int            n_fail = 0, n_compared = 0;

  psc_pad_model #(.HOLD_CYC(20), .NP(NP)) pads (.mclk_i(mclk_i), .pull_rst_i(pull_rst),
    .ext_i(ext), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_in_o(pad_in), .init_n_o(init_n));
  psc_pin_state_control DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .external_init_input_n_i(init_n), .lvd_reset_i(lvd), .first_run_i(first_run),
    .sleep_req_i(sleep), .stop_req_i(stop), .stop_float_select_i(fsel), .irq_sel_i(irq_sel),
    .irq_en_i(irq_en), .func_out_i(func_out), .func_oe_i(func_oe), .pad_in_i(pad_in),
    .nonmaskable_irq_input_n_i(nmi_in_n), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .core_in_o(core_in), .nmi_n_o(nmi_n), .state_o(state));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(input logic [NP-1:0] seen, input logic [NP-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs change only at falling edges, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    nmi_in_n = 1'b0;
    cyc(5);
    chk({50'h0, state}, {50'h0, PSC_ST_RESET});
    chk(pad_oe, '0);
    chk(core_in, '0);
    chk({52'h0, nmi_n}, '0);
    nmi_in_n = 1'b1;
    cyc(20);
    chk({50'h0, state}, {50'h0, PSC_ST_POSTRST});
    chk(pad_oe, '0);
    chk(core_in, EXT_V & ~ANA_M);
  endtask
  // function value set a cycle ahead so it is the state prior to entry;
  // it changes after entry, so a live path would show the new value
  task automatic t_hold(input logic use_stop);
    func_oe = ONES;
    func_out = VAL_A;
    cyc(1);
    sleep = !use_stop;
    stop = use_stop;
    nmi_in_n = 1'b0;
    cyc(2);
    func_out = VAL_B;
    cyc(3);
    chk(pad_out, (VAL_A & ~IRQ_M) | (VAL_B & IRQ_M));
    chk(pad_oe, ONES);
    chk(core_in & IRQ_M, VAL_B & IRQ_M);
    chk({52'h0, nmi_n}, '0);
    sleep = 1'b0;
    stop = 1'b0;
    nmi_in_n = 1'b1;
    cyc(1);
    chk(pad_out, VAL_B);
  endtask
  task automatic t_float();
    irq_sel = 7'h55;
    irq_en = 7'h33;
    stop = 1'b1;
    fsel = 1'b1;
    cyc(3);
    chk(pad_oe, '0);
    chk(core_in, EXT_V & 53'h11);
    stop = 1'b0;
    cyc(1);
    chk(pad_oe, ONES);
  endtask
  task automatic t_resets();
    first_run = 1'b0;
    lvd = 1'b1;
    cyc(1);
    chk(pad_oe | core_in, '0);
    lvd = 1'b0;
    cyc(1);
    chk({50'h0, state}, {50'h0, PSC_ST_POSTRST});
    chk(core_in, EXT_V & ~ANA_M);
    pull_rst = 1'b1;
    cyc(4);
    chk(pad_oe | core_in, '0);
    pull_rst = 1'b0;
    cyc(4);
    chk({50'h0, state}, {50'h0, PSC_ST_POSTRST});
    chk(core_in, EXT_V & ~ANA_M);
  endtask

  // watchdog: the whole sequence needs well under a microsecond
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
  initial begin
    cyc(3);
    reset_n_i = 1'b1;
    t_powerup();
    first_run = 1'b1;
    cyc(2);
    chk({50'h0, state}, {50'h0, PSC_ST_RUN});
    t_hold(1'b0);
    t_hold(1'b1);
    t_float();
    t_resets();
    stop_test();
  end
endmodule // testbench
